//--- design/light_sample_fifo_config.sv
/*
 Light sample buffer: write configuration, 512-byte store, fill level,
 trip interrupt and the register port behind the serial interface.
 Assumes the serial front end gives one read or write strobe per register
 access with the offset, and takes read data one cycle after the strobe.
*/
// Notes on behaviour
// - Enable bit pushes modulator zero ambient
// - Enable bit pushes modulator one ambient
// - Ambient only when flicker is off in step, done or deferred
// - Per-modulator flicker compression enable bit
// - Delta bit writes flicker sample differences only
// - Width field N keeps bits 0..N
// - Interrupt when level exceeds trip level
// - Byte level, high bits in first status
// - Second status holds low level bits
// - Data read pops one byte
// - Lost data sets sticky overflow flag
`timescale 1ns/100ps
`include "light_fifo_consts.svh"

module light_sample_fifo_config #(
   parameter int CNT_W = 16
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   // Register port behind the serial interface
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Loose control bits
   input wire logic buffer_flush_in,
   input wire logic power_on_bit_in,
   // Sequencer view
   input wire logic flicker_step_en_in,
   input wire logic [CNT_W-1:0] ambient_sample_count_in,
   input wire logic [CNT_W-1:0] flicker_sample_count_in,
   input wire logic ambient_finish_after_flicker_in,
   // Sample sources
   input wire logic amb0_valid_in,
   input wire logic [`SAMPLE_W-1:0] amb0_data_in,
   input wire logic amb1_valid_in,
   input wire logic [`SAMPLE_W-1:0] amb1_data_in,
   input wire logic flk0_valid_in,
   input wire logic [`SAMPLE_W-1:0] flk0_data_in,
   input wire logic flk1_valid_in,
   input wire logic [`SAMPLE_W-1:0] flk1_data_in,
   // Status and configuration outward
   output logic buffer_irq_out,
   output logic mod0_flicker_compress_en_out,
   output logic mod1_flicker_compress_en_out
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_ff; // First stage, read only by the second
   logic rst_sync_ff; // Released reset used everywhere else

   // Assert at once, release after two edges
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Sample packer
   // ----------------------------------------------------------------
   light_fifo_pkg::core_state_t s_ff; // Registered state
   light_fifo_pkg::core_state_t nxt_s; // Next state
   byte_push_if push_bus ();          // Bytes from the packer

   sample_packer #(
      .CNT_W(CNT_W)
   ) packer (
      .clock_in(clock_in),
      .rst_sync_n_in(rst_sync_ff),
      .cfg0_in(s_ff.cfg0),
      .cfg1_in(s_ff.cfg1),
      .flicker_step_en_in(flicker_step_en_in),
      .ambient_sample_count_in(ambient_sample_count_in),
      .flicker_sample_count_in(flicker_sample_count_in),
      .ambient_finish_after_flicker_in(ambient_finish_after_flicker_in),
      .amb0_valid_in(amb0_valid_in),
      .amb0_data_in(amb0_data_in),
      .amb1_valid_in(amb1_valid_in),
      .amb1_data_in(amb1_data_in),
      .flk0_valid_in(flk0_valid_in),
      .flk0_data_in(flk0_data_in),
      .flk1_valid_in(flk1_valid_in),
      .flk1_data_in(flk1_data_in),
      .push(push_bus)
   );

   // ----------------------------------------------------------------
   // Working terms
   // ----------------------------------------------------------------
   logic clr;     // Flush or power-on rising edge
   logic pop;     // A byte leaves this cycle
   logic take;    // A byte enters this cycle
   logic ovf_set; // Data lost this cycle
   logic unf_set; // Empty read this cycle
   logic [`LVL_W-1:0] trip_full; // Trip level at full width

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      pop = 1'b0;
      unf_set = 1'b0;
      nxt_s.pon_q = power_on_bit_in;
      // Power-on counts on its rising edge only
      clr = buffer_flush_in || (power_on_bit_in && !s_ff.pon_q);
      // Register writes; reserved bit 6 stays zero
      if (reg_wr_in) begin
         case (reg_addr_in)
            `ADDR_MOD0_CFG: begin
               nxt_s.cfg0 = reg_wdata_in & `CFG_WMASK;
            end
            `ADDR_MOD1_CFG: begin
               nxt_s.cfg1 = reg_wdata_in & `CFG_WMASK;
            end
            `ADDR_TRIP: begin
               nxt_s.trip = reg_wdata_in;
            end
            default: begin
               // Status and data are read only
            end
         endcase
      end

      // Register reads; unmapped offsets return zero
      if (reg_rd_in) begin
         case (reg_addr_in)
            `ADDR_MOD0_CFG: begin
               nxt_s.rdata = s_ff.cfg0;
            end
            `ADDR_MOD1_CFG: begin
               nxt_s.rdata = s_ff.cfg1;
            end
            `ADDR_TRIP: begin
               nxt_s.rdata = s_ff.trip;
            end
            `ADDR_COUNT_HIGH: begin
               nxt_s.rdata = s_ff.level[`LVL_W-1:2];
               nxt_s.snap_low = s_ff.level[1:0];
            end
            `ADDR_FLAGS_LOW: begin
               nxt_s.rdata = {s_ff.ovf, s_ff.unf, 4'h0, s_ff.snap_low};
            end
            `ADDR_DATA: begin
               if (s_ff.level != 10'h000) begin
                  nxt_s.rdata = s_ff.mem[s_ff.rptr];
                  pop = 1'b1;
               end else begin
                  nxt_s.rdata = 8'h00;
                  unf_set = 1'b1;
               end
            end
            default: begin
               nxt_s.rdata = 8'h00;
            end
         endcase
      end

      // A byte is taken unless the store is full or being cleared
      take = push_bus.valid && (s_ff.level != `LVL_FULL) && !clr;
      ovf_set = (push_bus.valid && (s_ff.level == `LVL_FULL)) ||
         push_bus.lost;
      // Storage and pointers
      if (take) begin
         nxt_s.mem[s_ff.wptr] = push_bus.data;
         nxt_s.wptr = s_ff.wptr + 9'h001;
      end
      if (pop) begin
         nxt_s.rptr = s_ff.rptr + 9'h001;
      end
      case ({take, pop})
         2'b10: begin
            nxt_s.level = s_ff.level + 10'h001;
         end
         2'b01: begin
            nxt_s.level = s_ff.level - 10'h001;
         end
         default: begin
            // Both or neither: level holds
         end
      endcase
      // Clear empties the store; a read in the same cycle still answers
      if (clr) begin
         nxt_s.wptr = '0;
         nxt_s.rptr = '0;
         nxt_s.level = '0;
      end

      nxt_s.ovf = (s_ff.ovf && !clr) || ovf_set;
      nxt_s.unf = (s_ff.unf && !clr) || unf_set;
      trip_full = {1'b0, nxt_s.trip, 1'b0};
      nxt_s.irq = nxt_s.level > trip_full;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Storage is cleared too so reads after reset are defined
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         s_ff <= '0;
         s_ff.cfg0 <= `CFG_RESET;
         s_ff.cfg1 <= `CFG_RESET;
         s_ff.trip <= `TRIP_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign reg_rdata_out = s_ff.rdata;
   assign buffer_irq_out = s_ff.irq;
   assign mod0_flicker_compress_en_out = s_ff.cfg0[`CFG_CMP_BIT];
   assign mod1_flicker_compress_en_out = s_ff.cfg1[`CFG_CMP_BIT];

endmodule

//--- design/light_fifo_consts.svh
/*
 Constants of the light sample buffer: register offsets, field positions,
 reset values and buffer geometry.
 Assumes it is included by bare name wherever these names are used.
*/
`ifndef LIGHT_FIFO_CONSTS_SVH
`define LIGHT_FIFO_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_MOD0_CFG 8'hF9
`define ADDR_MOD1_CFG 8'hFA
`define ADDR_TRIP 8'hFC
`define ADDR_COUNT_HIGH 8'hFD
`define ADDR_FLAGS_LOW 8'hFE
`define ADDR_DATA 8'hFF

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CFG_AMB_BIT 7
`define CFG_CMP_BIT 5
`define CFG_DLT_BIT 4
`define CFG_WID_MSB 3
`define CFG_WMASK 8'hBF
`define CFG_RESET 8'h8F
`define TRIP_RESET 8'h7F

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define FIFO_BYTES 512
`define PTR_W 9
`define LVL_W 10
`define LVL_FULL 10'h200
`define SAMPLE_W 16

`endif

//--- design/light_fifo_pkg.sv
/*
 Types of the light sample buffer: the state records of its two modules.
 Assumes the constants header is on the include path.
*/
`include "light_fifo_consts.svh"

package light_fifo_pkg;

   // ----------------------------------------------------------------
   // State of the buffer core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfg0;                 // Modulator zero write config
      logic [7:0] cfg1;                 // Modulator one write config
      logic [7:0] trip;                 // Trip level, bits 8:1
      logic [1:0] snap_low;             // Low level bits caught on high read
      logic ovf;                        // Data lost on full buffer or dropped sample
      logic unf;                        // Read of an empty buffer
      logic pon_q;                      // Last power-on level
      logic [`PTR_W-1:0] wptr;          // Write pointer
      logic [`PTR_W-1:0] rptr;          // Read pointer
      logic [`LVL_W-1:0] level;         // Bytes held
      logic irq;                        // Fill interrupt
      logic [7:0] rdata;                // Register read data
      logic [`FIFO_BYTES-1:0][7:0] mem; // Byte storage
   } core_state_t;

   // ----------------------------------------------------------------
   // State of the sample packer
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`SAMPLE_W-1:0] prev0;      // Last flicker sample, modulator 0
      logic [`SAMPLE_W-1:0] prev1;      // Last flicker sample, modulator 1
      logic [`SAMPLE_W-1:0] word;       // Word being sent, low byte next
      logic [1:0] left;                 // Bytes still to send
      logic valid;                      // Byte offered this cycle
      logic [7:0] data;                 // Byte offered
      logic lost;                       // A sample was dropped
   } packer_state_t;

endpackage

//--- design/byte_push_if.sv
/*
 Byte push carrier from the sample packer to the buffer core.
 Assumes the core takes every offered byte; a full buffer or one being cleared drops it.
*/
`timescale 1ns/100ps

interface byte_push_if;
   logic valid;      // Byte offered, one-cycle pulse
   logic [7:0] data; // Byte value
   logic lost;       // A whole sample was dropped, one-cycle pulse

   // ----------------------------------------------------------------
   // Ends
   // ----------------------------------------------------------------
   modport src (output valid, output data, output lost);
   modport dst (input valid, input data, input lost);
endinterface

//--- design/sample_packer.sv
/*
 Sample packer: gates, delta-codes and trims samples of both modulators
 and sends them as bytes, low byte first.
 Assumes a synchronised active-low reset and one request spacing of at
 least three cycles across all sources (two after a one-byte sample); closer ones are dropped and flagged.
*/
`timescale 1ns/100ps
`include "light_fifo_consts.svh"

module sample_packer #(
   parameter int CNT_W = 16
) (
   input wire logic clock_in,
   input wire logic rst_sync_n_in,
   input wire logic [7:0] cfg0_in,
   input wire logic [7:0] cfg1_in,
   input wire logic flicker_step_en_in,
   input wire logic [CNT_W-1:0] ambient_sample_count_in,
   input wire logic [CNT_W-1:0] flicker_sample_count_in,
   input wire logic ambient_finish_after_flicker_in,
   input wire logic amb0_valid_in,
   input wire logic [`SAMPLE_W-1:0] amb0_data_in,
   input wire logic amb1_valid_in,
   input wire logic [`SAMPLE_W-1:0] amb1_data_in,
   input wire logic flk0_valid_in,
   input wire logic [`SAMPLE_W-1:0] flk0_data_in,
   input wire logic flk1_valid_in,
   input wire logic [`SAMPLE_W-1:0] flk1_data_in,
   byte_push_if.src push
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Keep bits 0..msb of a sample
   function automatic logic [`SAMPLE_W-1:0] trim(
      input logic [`SAMPLE_W-1:0] v, input logic [3:0] msb);
      logic [`SAMPLE_W:0] m;
      m = (17'h0_0001 << (msb + 5'h01)) - 17'h0_0001;
      return v & m[`SAMPLE_W-1:0];
   endfunction

   // One byte up to eight bits, two above
   function automatic logic [1:0] nbytes(input logic [3:0] msb);
      return (msb > 4'h7) ? 2'h2 : 2'h1;
   endfunction

   light_fifo_pkg::packer_state_t s_ff, nxt_s;
   logic amb_ok;   // Ambient data may enter
   logic [3:0] req; // Requests: amb0, amb1, flk0, flk1
   logic [`SAMPLE_W-1:0] f0, f1; // Coded flicker words

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.valid = 1'b0;
      nxt_s.lost = 1'b0;
      amb_ok = !flicker_step_en_in ||
         (ambient_sample_count_in >= flicker_sample_count_in) ||
         ambient_finish_after_flicker_in;
      req[0] = amb0_valid_in && cfg0_in[`CFG_AMB_BIT] && amb_ok;
      req[1] = amb1_valid_in && cfg1_in[`CFG_AMB_BIT] && amb_ok;
      req[2] = flk0_valid_in;
      req[3] = flk1_valid_in;
      f0 = cfg0_in[`CFG_DLT_BIT] ? flk0_data_in - s_ff.prev0 : flk0_data_in;
      f1 = cfg1_in[`CFG_DLT_BIT] ? flk1_data_in - s_ff.prev1 : flk1_data_in;
      // History follows every sample so deltas stay consistent
      if (flk0_valid_in) begin
         nxt_s.prev0 = flk0_data_in;
      end
      if (flk1_valid_in) begin
         nxt_s.prev1 = flk1_data_in;
      end
      // Send the pending byte
      if (s_ff.left != 2'h0) begin
         nxt_s.valid = 1'b1;
         nxt_s.data = s_ff.word[7:0];
         nxt_s.word = s_ff.word >> 8;
         nxt_s.left = s_ff.left - 2'h1;
         nxt_s.lost = (req != 4'h0);
      end else if (req[0]) begin
         nxt_s.word = amb0_data_in;
         nxt_s.left = 2'h2;
         nxt_s.lost = (req[3:1] != 3'h0);
      end else if (req[1]) begin
         nxt_s.word = amb1_data_in;
         nxt_s.left = 2'h2;
         nxt_s.lost = (req[3:2] != 2'h0);
      end else if (req[2]) begin
         nxt_s.word = trim(f0, cfg0_in[`CFG_WID_MSB:0]);
         nxt_s.left = nbytes(cfg0_in[`CFG_WID_MSB:0]);
         nxt_s.lost = req[3];
      end else if (req[3]) begin
         nxt_s.word = trim(f1, cfg1_in[`CFG_WID_MSB:0]);
         nxt_s.left = nbytes(cfg1_in[`CFG_WID_MSB:0]);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_sync_n_in) begin
      if (!rst_sync_n_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign push.valid = s_ff.valid;
   assign push.data = s_ff.data;
   assign push.lost = s_ff.lost;

endmodule

//--- tb/light_fifo_assertions.sv
/*
 Checker of the light sample buffer: properties on the top ports.
 Assumes a bind from the bench and the constants header on the path.
*/
`timescale 1ns/100ps
`include "light_fifo_consts.svh"

module light_fifo_assertions (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic buffer_flush_in,
   input wire logic power_on_bit_in,
   input wire logic amb0_valid_in,
   input wire logic amb1_valid_in,
   input wire logic flk0_valid_in,
   input wire logic flk1_valid_in,
   input wire logic buffer_irq_out,
   input wire logic mod0_flicker_compress_en_out,
   input wire logic mod1_flicker_compress_en_out
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic any_valid; // Some sample offered
   logic wr0; // Write to config zero
   logic wr1; // Write to config one
   logic host_act; // Host touched the block this cycle
   assign any_valid = amb0_valid_in | amb1_valid_in | flk0_valid_in |
      flk1_valid_in;
   assign wr0 = reg_wr_in && reg_addr_in == `ADDR_MOD0_CFG;
   assign wr1 = reg_wr_in && reg_addr_in == `ADDR_MOD1_CFG;
   assign host_act = reg_rd_in | reg_wr_in | buffer_flush_in |
      power_on_bit_in;

   // One domain, so one clock and one disable for all
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   // compress bits of both modulators, read data and interrupt
   a_cmp0_follows: assert property (wr0 |=>
      mod0_flicker_compress_en_out == $past(reg_wdata_in[5]))
      else $error("compress enable zero missed its write");
   a_cmp1_follows: assert property (wr1 |=>
      mod1_flicker_compress_en_out == $past(reg_wdata_in[5]))
      else $error("compress enable one missed its write");
   a_cmp_quiet: assert property (!wr0 && !wr1 |=>
      $stable(mod0_flicker_compress_en_out) &&
      $stable(mod1_flicker_compress_en_out))
      else $error("compress enable moved without a write");
   a_cfg_readback: assert property (reg_rd_in && !reg_wr_in &&
      reg_addr_in == `ADDR_MOD0_CFG |=>
      reg_rdata_out[5] == mod0_flicker_compress_en_out &&
      !reg_rdata_out[6])
      else $error("config zero readback disagrees");
   a_status_resvd: assert property (reg_rd_in &&
      reg_addr_in == `ADDR_FLAGS_LOW |=> reg_rdata_out[5:2] == 4'h0)
      else $error("second status spare bits not zero");
   a_rdata_holds: assert property (!reg_rd_in |=>
      $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_irq_reset: assert property ($rose(rstn_in) |->
      (!buffer_irq_out) [*3])
      else $error("interrupt raised on an empty buffer");
   a_irq_cause: assert property ($changed(buffer_irq_out) |->
      $past(host_act) || $past(any_valid, 3) || $past(any_valid, 4))
      else $error("interrupt moved with no level change");
endmodule

//--- tb/host_side_model.sv
/*
 Host side of the register port: single register accesses.
 Assumes read data stands from the edge after the strobe.
*/
`timescale 1ns/100ps

module host_side_model (
   input wire logic clock_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_rd_out
);
   // Idle port at time zero
   initial begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_rd_out = 1'b0;
   end

   // ----------------------------------------------------------------
   // One strobe cycle per access, driven at the falling edge
   // ----------------------------------------------------------------
   task automatic access(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge clock_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = wr;
      reg_rd_out = !wr;
      @(negedge clock_in);
      q = reg_rdata_in;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      // Released lines flip so a stale value cannot pass
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      access(1'b1, a, d, q);
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
      access(1'b0, a, 8'h00, q);
   endtask

   task automatic read_level(output logic [9:0] lvl,
      output logic [7:0] st);
      logic [7:0] hi;
      read_reg(8'hFD, hi);
      read_reg(8'hFE, st);
      lvl = {hi, st[1:0]};
   endtask
endmodule

//--- tb/light_sample_fifo_config_bench.sv
/*
 Bench of the light sample buffer: register sequences with expectations.
 Assumes the host model and the checker are compiled alongside.
*/
`timescale 1ns/100ps

bind light_sample_fifo_config light_fifo_assertions i_chk (
   .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .buffer_flush_in(buffer_flush_in), .power_on_bit_in(power_on_bit_in),
   .amb0_valid_in(amb0_valid_in), .amb1_valid_in(amb1_valid_in),
   .flk0_valid_in(flk0_valid_in), .flk1_valid_in(flk1_valid_in),
   .buffer_irq_out(buffer_irq_out),
   .mod0_flicker_compress_en_out(mod0_flicker_compress_en_out),
   .mod1_flicker_compress_en_out(mod1_flicker_compress_en_out));

module light_sample_fifo_config_bench;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [7:0] ad, wd, rd_q, rb, st;
   logic wr, rd, irq, cmp0, cmp1;
   logic flush_q = 1'b0; // Buffer clear
   logic power_on_bit = 1'b0; // Power-on bit
   logic step = 1'b0; // Flicker on in step
   logic fin = 1'b0; // Ambient finish after flicker
   logic [15:0] acnt = 16'h0004, fcnt = 16'h0005, sd = 16'h0000, w;
   logic [3:0] vld = 4'h0; // amb0, amb1, flk0, flk1
   logic [9:0] lvl;
   int n_errors = 0;
   int n_tests = 0;
   logic [7:0] ra [6] = '{8'hF9, 8'hFA, 8'hFC, 8'hFD, 8'hFE, 8'h10};
   logic [7:0] re [6] = '{8'h8F, 8'h8F, 8'h7F, 8'h00, 8'h00, 8'h00};
   logic [3:0] wn [4] = '{4'h0, 4'h7, 4'h8, 4'hF};
   int ds [3] = '{3, 3, 2};
   logic [15:0] di [3] = '{16'h0300, 16'h0250, 16'h0001};
   logic [15:0] dx [3] = '{16'h0300, 16'hFF50, 16'h4918};

   always #2 clock_in = ~clock_in;

   light_sample_fifo_config i_dut (
      .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(ad),
      .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd),
      .reg_rdata_out(rd_q), .buffer_flush_in(flush_q),
      .power_on_bit_in(power_on_bit), .flicker_step_en_in(step),
      .ambient_sample_count_in(acnt), .flicker_sample_count_in(fcnt),
      .ambient_finish_after_flicker_in(fin),
      .amb0_valid_in(vld[0]), .amb0_data_in(sd),
      .amb1_valid_in(vld[1]), .amb1_data_in(sd),
      .flk0_valid_in(vld[2]), .flk0_data_in(sd),
      .flk1_valid_in(vld[3]), .flk1_data_in(sd),
      .buffer_irq_out(irq), .mod0_flicker_compress_en_out(cmp0),
      .mod1_flicker_compress_en_out(cmp1));

   host_side_model i_host (
      .clock_in(clock_in), .reg_rdata_in(rd_q), .reg_addr_out(ad),
      .reg_wr_out(wr), .reg_wdata_out(wd), .reg_rd_out(rd));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One sample pulse, then room for both bytes to land
   task automatic push(input int src, input logic [15:0] d);
      @(negedge clock_in);
      sd = d;
      vld[src] = 1'b1;
      @(negedge clock_in);
      vld = 4'h0;
      sd = ~d;
      repeat (3) @(negedge clock_in);
   endtask

   task automatic pop(input logic [7:0] e);
      i_host.read_reg(8'hFF, rb);
      check("data byte", {8'h00, rb}, {8'h00, e});
   endtask

   task automatic lvl_is(input logic [9:0] e);
      i_host.read_level(lvl, st);
      check("level", {6'h00, lvl}, {6'h00, e});
   endtask

   task automatic flush();
      @(negedge clock_in);
      flush_q = 1'b1;
      @(negedge clock_in);
      flush_q = 1'b0;
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under 8000 cycles
   initial begin
      repeat (40000) @(posedge clock_in);
      n_errors++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clock_in);
      rstn_in = 1'b1;
      repeat (3) @(negedge clock_in);
      foreach (ra[i]) begin
         i_host.read_reg(ra[i], rb);
         check("reset value", rb, re[i]);
      end
      check("compress", {cmp1, cmp0}, 2'b00);
      $display("test reset done");
      i_host.write_reg(8'hF9, 8'hFF);
      i_host.write_reg(8'hFA, 8'h20);
      i_host.write_reg(8'hFD, 8'h55);
      i_host.read_reg(8'hF9, rb);
      check("cfg0", rb, 8'hBF);
      i_host.read_reg(8'hFA, rb);
      check("cfg1", rb, 8'h20);
      check("compress", {cmp1, cmp0}, 2'b11);
      lvl_is(10'h000);
      i_host.write_reg(8'hF9, 8'h8F);
      i_host.write_reg(8'hFA, 8'h8F);
      $display("test config done");
      for (int i = 0; i < 8; i++) begin
         step = i[2];
         acnt = i[1] ? 16'h0005 : 16'h0004;
         fin = i[0];
         push(0, 16'h1234);
         lvl_is((!i[2] || i[1] || i[0]) ? 10'h002 : 10'h000);
         if (lvl == 10'h002) begin
            pop(8'h34);
            pop(8'h12);
         end
      end
      step = 1'b0;
      for (int m = 0; m < 2; m++) begin
         i_host.write_reg(8'hF9 + m[7:0], 8'h0F);
         push(m, 16'hA5C3);
         lvl_is(10'h000);
         i_host.write_reg(8'hF9 + m[7:0], 8'h8F);
         push(m, 16'hA5C3);
         pop(8'hC3);
         pop(8'hA5);
      end
      $display("test ambient done");
      foreach (wn[k]) begin
         i_host.write_reg(8'hF9, {4'h0, wn[k]});
         push(2, 16'hB6E9);
         w = 16'hB6E9 & 16'((32'h1 << (wn[k] + 1)) - 1);
         pop(w[7:0]);
         if (wn[k] > 4'h7) pop(w[15:8]);
         lvl_is(10'h000);
      end
      i_host.write_reg(8'hF9, 8'h1F);
      i_host.write_reg(8'hFA, 8'h1F);
      foreach (ds[k]) begin
         push(ds[k], di[k]);
         pop(dx[k][7:0]);
         pop(dx[k][15:8]);
      end
      $display("test flicker done");
      flush();
      i_host.write_reg(8'hF9, 8'h87);
      i_host.write_reg(8'hFC, 8'h00);
      check("irq", irq, 1'b0);
      push(2, 16'h0077);
      check("irq", irq, 1'b1);
      i_host.write_reg(8'hFC, 8'h01);
      check("irq", irq, 1'b0);
      push(0, 16'h2211);
      check("irq", irq, 1'b1);
      i_host.read_reg(8'hFD, rb);
      pop(8'h77);
      check("irq", irq, 1'b0);
      i_host.read_reg(8'hFE, rb);
      check("snapshot", rb, 8'h03);
      lvl_is(10'h002);
      $display("test threshold done");
      flush();
      i_host.write_reg(8'hF9, 8'h8F);
      i_host.write_reg(8'hFC, 8'h7F);
      for (int i = 0; i < 256; i++) push(0, {8'h5A, i[7:0]});
      lvl_is(10'h200);
      check("overflow", st[7], 1'b0);
      push(0, 16'hDEAD);
      lvl_is(10'h200);
      check("overflow", st[7], 1'b1);
      check("irq", irq, 1'b1);
      for (int i = 0; i < 256; i++) begin
         pop(i[7:0]);
         pop(8'h5A);
      end
      lvl_is(10'h000);
      check("flags", st[7:6], 2'b10);
      pop(8'h00);
      lvl_is(10'h000);
      check("flags", st[7:6], 2'b11);
      @(negedge clock_in);
      power_on_bit = 1'b1;
      i_host.read_reg(8'hFE, rb);
      check("flags", rb, 8'h00);
      pop(8'h00);
      flush();
      i_host.read_reg(8'hFE, rb);
      check("flags", rb, 8'h00);
      vld[0] = 1'b1;
      push(2, 16'h0000);
      i_host.read_reg(8'hFE, rb);
      check("collision", rb[7], 1'b1);
      $display("test full done");
      report_and_stop();
   end
endmodule
